// file: include/flag_pkg.sv
// constants shared by the flag bus router and its pin filter
package flag_pkg;

   // ****************************************************
   // bus widths
   // ****************************************************
   localparam int FLAG_W = 16;          // width of the shared flag bus
   localparam int PIN_N = 13;           // flags that own a device pin
   localparam int START_N = 6;          // trigger inputs among the pins
   localparam int START_POS = 3;        // flag number of trigger_input_1
   localparam int FIXED_PIN_N = 3;      // low flags that are always pins
   localparam int ADDR_W = 12;          // axi byte address width
   localparam int DATA_W = 32;          // axi data width

   // ****************************************************
   // register indices, byte address is four times the index
   // ****************************************************
   localparam logic [9:0] DIR_IDX = 10'h01C1;   // flag_direction
   localparam logic [9:0] POL_IDX = 10'h01C2;   // flag_polarity
   localparam logic [9:0] SRC_IDX = 10'h01C3;   // flag_source_select

   // ****************************************************
   // reset values and field masks
   // ****************************************************
   localparam logic [15:0] DIR_RESET = 16'h1FFF;  // every pin an input
   localparam logic [15:0] POL_RESET = 16'h0000;  // all direct
   localparam logic [15:0] SRC_RESET = 16'h1207;  // debug and interrupt pins as flags
   localparam logic [15:0] SRC_MASK = 16'h1FF8;   // writable source bits 12..3
   localparam logic [15:0] PIN_MASK = 16'h1FFF;   // bits that exist in dir and pol

   // ****************************************************
   // timing
   // ****************************************************
   localparam int FILTER_CYCLES = 3;    // anti-glitch window in system clocks

   // ****************************************************
   // axi responses
   // ****************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : flag_pkg

// file: verilog/pin_filter.sv
// three-stage pin synchroniser followed by a stability filter
`timescale 1ns/1ps
module pin_filter #(
   parameter int CYCLES = flag_pkg::FILTER_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // raw pin level and filtered result
   input wire logic pin_level,
   output logic filt_level
);
   import flag_pkg::*;

   // ****************************************************
   // synchroniser
   // ****************************************************
   logic meta_r;     // first stage, read only by sync_b_r
   logic sync_b_r;   // second stage
   logic sync_c_r;   // third stage
   logic [1:0] cnt_r;  // cycles the new level has held
   logic filt_r;       // filtered level

   // plain three-flop chain, no logic between stages
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_b_r <= 1'b0;
         sync_c_r <= 1'b0;
      end else begin
         meta_r <= pin_level;
         sync_b_r <= meta_r;
         sync_c_r <= sync_b_r;
      end
   end

   // ****************************************************
   // stability filter
   // ****************************************************
   // a level counts only when stages two and three agree
   wire agreed = (sync_b_r == sync_c_r);
   wire differs = agreed && (sync_c_r != filt_r);
   wire [1:0] cnt_nxt = differs ? cnt_r + 2'd1 : 2'd0;
   wire settle = differs && (cnt_nxt == 2'(CYCLES));

   // pulses of up to three clocks reset the count, so such a glitch never reaches the bus
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 2'd0;
         filt_r <= 1'b0;
      end else begin
         cnt_r <= settle ? 2'd0 : cnt_nxt;
         if (settle) begin
            filt_r <= sync_c_r;
         end
      end
   end

   assign filt_level = filt_r;

endmodule : pin_filter

// file: verilog/flag_bus_routing.sv
// flag bus merge, pin routing and its axi4-lite configuration registers
`timescale 1ns/1ps
module flag_bus_routing (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // channel flag copies
   input wire logic [flag_pkg::FLAG_W-1:0] chan_a_flags,
   input wire logic [flag_pkg::FLAG_W-1:0] chan_b_flags,
   // merged bus back to both channels
   output logic [flag_pkg::FLAG_W-1:0] flag_bus,
   // device pins: general_pin_0..2, trigger_input_1..6,
   // interrupt_out_pin, amplifier_out_1..2, debug_pin
   input wire logic [flag_pkg::PIN_N-1:0] pin_in,
   output logic [flag_pkg::PIN_N-1:0] pin_out,
   output logic [flag_pkg::PIN_N-1:0] pin_oe,
   // original pin functions of the rest of the device
   input wire logic [flag_pkg::PIN_N-1:0] func_out,
   input wire logic [flag_pkg::PIN_N-1:0] func_oe,
   output logic [flag_pkg::PIN_N-1:0] func_in,
   output logic [flag_pkg::START_N-1:0] start_active,
   // axi4-lite write address
   input wire logic [flag_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [flag_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [flag_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [flag_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import flag_pkg::*;

   // ****************************************************
   // configuration registers
   // ****************************************************
   logic [15:0] dir_r;   // 1 = input flag, 0 = output flag
   logic [15:0] pol_r;   // 1 = inverted between bus and pin
   logic [15:0] src_r;   // 1 = pin used as flag

   // ****************************************************
   // bus slave state
   // ****************************************************
   logic awready_r;      // one-cycle address ready offer
   logic wready_r;       // one-cycle data ready offer
   logic aw_got_r;       // address captured
   logic w_got_r;        // data captured
   logic [ADDR_W-1:0] waddr_r;  // captured write address
   logic [15:0] wdata_r;        // captured low half of data
   logic [1:0] wstrb_r;         // lanes that matter here
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;

   // ****************************************************
   // routing state
   // ****************************************************
   logic [FLAG_W-1:0] bus_r;
   logic [PIN_N-1:0] pin_out_r;
   logic [PIN_N-1:0] pin_oe_r;
   logic [PIN_N-1:0] func_in_r;
   logic [START_N-1:0] start_r;

   // ****************************************************
   // merge of the two channel copies
   // ****************************************************
   // each channel pulls a flag low independently; AND keeps either low
   wire [FLAG_W-1:0] merged = chan_a_flags & chan_b_flags;

   // ****************************************************
   // filtered pin levels, one filter per pin
   // ****************************************************
   wire [PIN_N-1:0] filt;

   genvar g;
   generate
      for (g = 0; g < PIN_N; g++) begin : g_filt
         pin_filter #(
            .CYCLES(FILTER_CYCLES)
         ) u_filt (
            .clock(clock),
            .rst_n(rst_n),
            .pin_level(pin_in[g]),
            .filt_level(filt[g])
         );
      end
   endgenerate

   // ****************************************************
   // mode decode per pin
   // ****************************************************
   // low three flags have no source bit and are always pins
   wire [PIN_N-1:0] src_eff = src_r[PIN_N-1:0] | PIN_MASK[PIN_N-1:0] & ~SRC_MASK[PIN_N-1:0];
   wire [PIN_N-1:0] as_input = src_eff & dir_r[PIN_N-1:0];
   wire [PIN_N-1:0] as_output = src_eff & ~dir_r[PIN_N-1:0];
   wire [PIN_N-1:0] pol = pol_r[PIN_N-1:0];

   // bus position fixed by pin index, never remapped
   wire [PIN_N-1:0] bus_low_nxt = (as_input & (filt ^ pol)) | (~as_input & merged[PIN_N-1:0]);
   wire [FLAG_W-1:0] bus_nxt = {merged[FLAG_W-1:PIN_N], bus_low_nxt};

   // output flag drives from merged flag, non-flag pin from original function, input flag drives nothing
   wire [PIN_N-1:0] pout_nxt = (as_output & (merged[PIN_N-1:0] ^ pol)) | (~src_eff & func_out);
   wire [PIN_N-1:0] poe_nxt = as_output | (~src_eff & func_oe);

   // original function sees the pin only while it owns it
   wire [PIN_N-1:0] fin_nxt = ~src_eff & filt;

   // trigger inputs with selectable active level
   wire [START_N-1:0] st_flag = src_eff[START_POS+START_N-1:START_POS];
   wire [START_N-1:0] st_lvl = filt[START_POS+START_N-1:START_POS];
   wire [START_N-1:0] st_pol = pol[START_POS+START_N-1:START_POS];
   wire [START_N-1:0] start_nxt = ~st_flag & (st_lvl ^ st_pol);

   // ****************************************************
   // routing registers
   // ****************************************************
   // every output is a flop; adds one clock of latency to the bus
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_r <= '0;
         pin_out_r <= '0;
         pin_oe_r <= '0;
         func_in_r <= '0;
         start_r <= '0;
      end else begin
         bus_r <= bus_nxt;
         pin_out_r <= pout_nxt;
         pin_oe_r <= poe_nxt;
         func_in_r <= fin_nxt;
         start_r <= start_nxt;
      end
   end

   // ****************************************************
   // write path decode
   // ****************************************************
   wire [9:0] widx = waddr_r[11:2];
   wire w_dir = (widx == DIR_IDX);
   wire w_pol = (widx == POL_IDX);
   wire w_src = (widx == SRC_IDX);
   wire w_hit = w_dir | w_pol | w_src;
   wire do_write = aw_got_r && w_got_r && !bvalid_r;
   // byte-lane mask over the 16-bit register
   wire [15:0] lane = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

   // merged value after byte lanes, reserved bits held at zero
   wire [15:0] dir_wr = ((dir_r & ~lane) | (wdata_r & lane)) & PIN_MASK;
   wire [15:0] pol_wr = ((pol_r & ~lane) | (wdata_r & lane)) & PIN_MASK;
   wire [15:0] src_wr = ((src_r & ~lane) | (wdata_r & lane)) & SRC_MASK;

   // ****************************************************
   // write address and data capture, either order
   // ****************************************************
   wire aw_take = s_axi_awvalid && awready_r;
   wire w_take = s_axi_wvalid && wready_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         awready_r <= 1'b0;
         aw_got_r <= 1'b0;
         waddr_r <= '0;
      end else begin
         // offer ready for one cycle, master holds valid until taken
         awready_r <= s_axi_awvalid && !awready_r && !aw_got_r && !bvalid_r;
         if (aw_take) begin
            aw_got_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_got_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wready_r <= 1'b0;
         w_got_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         wready_r <= s_axi_wvalid && !wready_r && !w_got_r && !bvalid_r;
         if (w_take) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata[15:0];
            wstrb_r <= s_axi_wstrb[1:0];
         end else if (do_write) begin
            w_got_r <= 1'b0;
         end
      end
   end

   // ****************************************************
   // register update and write response
   // ****************************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dir_r <= DIR_RESET;
         pol_r <= POL_RESET;
         src_r <= SRC_RESET & SRC_MASK;
      end else if (do_write) begin
         if (w_dir) dir_r <= dir_wr;
         if (w_pol) pol_r <= pol_wr;
         if (w_src) src_r <= src_wr;
      end
   end

   // unmapped writes are dropped and answered with slverr
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ****************************************************
   // read path
   // ****************************************************
   wire [9:0] ridx = s_axi_araddr[11:2];
   wire r_dir = (ridx == DIR_IDX);
   wire r_pol = (ridx == POL_IDX);
   wire r_src = (ridx == SRC_IDX);
   wire r_hit = r_dir | r_pol | r_src;
   // reserved source bits 2..0 read as ones: those pins are always flags
   wire [15:0] rd_src = src_r | (PIN_MASK & ~SRC_MASK);
   wire [15:0] rd_word = r_dir ? dir_r : r_pol ? pol_r : r_src ? rd_src : 16'h0000;
   wire ar_take = s_axi_arvalid && arready_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else begin
         arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
         if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= {16'h0000, rd_word};
            rresp_r <= r_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // ****************************************************
   // output drive
   // ****************************************************
   assign flag_bus = bus_r;
   assign pin_out = pin_out_r;
   assign pin_oe = pin_oe_r;
   assign func_in = func_in_r;
   assign start_active = start_r;
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_chan_change;
      $changed(chan_a_flags) || $changed(chan_b_flags);
   endsequence

   merge_and_a: assert property (
      bus_r[FLAG_W-1:PIN_N] == $past(chan_a_flags[FLAG_W-1:PIN_N] & chan_b_flags[FLAG_W-1:PIN_N])
   ) else $error("internal flags not the and of channels");

   internal_follow_a: assert property (
      s_chan_change |=> bus_r[FLAG_W-1:PIN_N] == $past(merged[FLAG_W-1:PIN_N])
   ) else $error("internal flags lag channels");

   default_route_a: assert property (
      (src_eff[9] == 1'b0) |=> bus_r[9] == $past(merged[9])
   ) else $error("unflagged pin position not from merged flag");

   input_flag_a: assert property (
      (as_input[0] && filt[0] != pol[0] && $stable(dir_r) && $stable(pol_r)) |=> bus_r[0]
   ) else $error("input flag not taken from filtered pin");

   output_flag_a: assert property (
      as_output[1] |=> pin_oe_r[1] && pin_out_r[1] == $past(merged[1] ^ pol[1])
   ) else $error("output flag pin not driven from merged flag");

   orig_cut_a: assert property (
      src_eff[12] |=> func_in_r[12] == 1'b0
   ) else $error("original function still sees flag pin");

   // low pins must act as flags whatever the source register holds
   fixed_src_a: assert property (
      func_in_r[2:0] == 3'b000 && src_r[2:0] == 3'b000
         && pin_oe_r[2:0] == $past(~dir_r[2:0])
   ) else $error("low flags lost their pin role");

   start_pol_a: assert property (
      (!st_flag[0] && st_pol[0] && !st_lvl[0]) |=> start_r[0]
   ) else $error("active low start not recognised");

   // a stored write answers next cycle, slverr only for unmapped words
   write_resp_a: assert property (
      do_write |=> bvalid_r && bresp_r == ($past(w_hit) ? RESP_OKAY : RESP_SLVERR)
   ) else $error("write response missing or wrong");

   // the response stands until the master takes it
   resp_hold_a: assert property (
      (bvalid_r && !s_axi_bready) |=> bvalid_r && $stable(bresp_r)
   ) else $error("write response dropped before bready");

endmodule : flag_bus_routing

// file: sim/flag_partner.sv
// model of the two channel blocks and the external pin drivers
`timescale 1ns/1ps
module flag_partner (
   // clock
   input wire logic clock,
   // commanded channel copies and external pin levels
   input wire logic [15:0] a_cmd,
   input wire logic [15:0] b_cmd,
   input wire logic [12:0] ext_lvl,
   // device side
   input wire logic [15:0] flag_bus,
   input wire logic [12:0] pin_out,
   input wire logic [12:0] pin_oe,
   output logic [15:0] chan_a_flags,
   output logic [15:0] chan_b_flags,
   output logic [12:0] pin_in,
   output logic [15:0] seen_bus
);
   // each channel drives only its private copy
   assign chan_a_flags = a_cmd;
   assign chan_b_flags = b_cmd;
   // wire level: device drive wins wherever it enables the pin
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
   // both channels take the shared bus as an input each edge
   always_ff @(posedge clock) begin
      seen_bus <= flag_bus;
   end
endmodule : flag_partner

// file: sim/flag_bus_routing_tb_top.sv
// self-checking bench for the flag bus router and its registers
`timescale 1ns/1ps
module flag_bus_routing_tb_top;
   import flag_pkg::*;
   // ****************************************************
   // signals
   // ****************************************************
   localparam logic [11:0] DIR_A = {DIR_IDX, 2'h0}; // byte addresses
   localparam logic [11:0] POL_A = {POL_IDX, 2'h0};
   localparam logic [11:0] SRC_A = {SRC_IDX, 2'h0};
   localparam logic [11:0] BAD_A = 12'h0710; // unmapped word
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic [15:0] a_cmd = 16'h0000;
   logic [15:0] b_cmd = 16'h0000;
   logic [12:0] ext_lvl = 13'h0000;
   logic [12:0] func_out = 13'h0000;
   logic [12:0] func_oe = 13'h0000;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] chan_a_flags, chan_b_flags, flag_bus, seen_bus;
   logic [12:0] pin_in, pin_out, pin_oe, func_in, lvl;
   logic [5:0] start_active;
   logic [15:0] pa [4] = '{16'hFFFF, 16'hA5A5, 16'h0F0F, 16'hE001}; // channel a patterns
   logic [15:0] pb [4] = '{16'h3C3C, 16'hFFFF, 16'h00FF, 16'hF00F}; // channel b patterns
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   // ****************************************************
   // instances
   // ****************************************************
   flag_bus_routing i_flag_bus_routing (.clock(clock), .rst_n(rst_n),
      .chan_a_flags(chan_a_flags), .chan_b_flags(chan_b_flags), .flag_bus(flag_bus),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .func_out(func_out),
      .func_oe(func_oe), .func_in(func_in), .start_active(start_active),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   flag_partner i_flag_partner (.clock(clock), .a_cmd(a_cmd), .b_cmd(b_cmd),
      .ext_lvl(ext_lvl), .flag_bus(flag_bus), .pin_out(pin_out), .pin_oe(pin_oe),
      .chan_a_flags(chan_a_flags), .chan_b_flags(chan_b_flags), .pin_in(pin_in),
      .seen_bus(seen_bus));
   // ****************************************************
   // clock and watchdog
   // ****************************************************
   initial begin
      forever #5 clock = ~clock;
   end
   // the whole run needs a few hundred cycles; far beyond means a hang
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   // ****************************************************
   // tasks
   // ****************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // offers address and data together, holds bready until the answer
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clock);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      check("rdata", ed, s_axi_rdata);
      check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : axi_rd
   // direction, polarity, source in one go
   task automatic cfg(input logic [15:0] d, input logic [15:0] p, input logic [15:0] s);
      axi_wr(DIR_A, {16'h0000, d}, RESP_OKAY);
      axi_wr(POL_A, {16'h0000, p}, RESP_OKAY);
      axi_wr(SRC_A, {16'h0000, s}, RESP_OKAY);
   endtask : cfg
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   // ****************************************************
   // tests
   // ****************************************************
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      // reset values, masks, reserved bits, unmapped word
      axi_rd(DIR_A, {16'h0000, DIR_RESET}, RESP_OKAY);
      axi_rd(POL_A, {16'h0000, POL_RESET}, RESP_OKAY);
      axi_rd(SRC_A, {16'h0000, SRC_RESET}, RESP_OKAY);
      axi_wr(SRC_A, 32'hFFFF_FFFF, RESP_OKAY);
      axi_rd(SRC_A, 32'h0000_1FFF, RESP_OKAY);
      axi_wr(SRC_A, 32'h0000_0000, RESP_OKAY);
      axi_rd(SRC_A, 32'h0000_0007, RESP_OKAY);
      // low byte lane only: the high source bits must stay clear
      s_axi_wstrb <= 4'h1;
      axi_wr(SRC_A, 32'h0000_FFFF, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axi_rd(SRC_A, 32'h0000_00FF, RESP_OKAY);
      axi_wr(SRC_A, 32'h0000_0000, RESP_OKAY);
      axi_wr(BAD_A, 32'h0000_FFFF, RESP_SLVERR);
      axi_rd(BAD_A, 32'h0000_0000, RESP_SLVERR);
      $display("test registers done");
      // default routing: merged flags reach the bus and both channels
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         a_cmd <= pa[i];
         b_cmd <= pb[i];
         repeat (3) @(posedge clock);
         check("bus_merged", {16'h0, (pa[i] & pb[i]) & 16'hFFF8}, flag_bus & 16'hFFF8);
         check("bus_low_pins", 32'h0, {29'h0, flag_bus[2:0]});
         check("chan_view", {16'h0, flag_bus}, {16'h0, seen_bus});
      end
      $display("test merge done");
      // every pin an output flag with some inverted
      cfg(16'h0000, 16'h0055, 16'hFFFF);
      @(posedge clock);
      a_cmd <= 16'hA5A5;
      b_cmd <= 16'hFFFF;
      repeat (3) @(posedge clock);
      check("bus_out", 32'h0000_A5A5, {16'h0, flag_bus});
      check("pin_out", {19'h0, 13'h05A5 ^ 13'h0055}, {19'h0, pin_out});
      check("pin_oe", 32'h0000_1FFF, {19'h0, pin_oe});
      check("func_in", 32'h0, {19'h0, func_in});
      check("start_off", 32'h0, {26'h0, start_active});
      $display("test output done");
      // every pin an input flag through the filter
      cfg(16'h1FFF, 16'h0000, 16'hFFFF);
      @(posedge clock);
      ext_lvl <= 13'h0AAA;
      repeat (10) @(posedge clock);
      check("bus_in", 32'h0000_0AAA, {19'h0, flag_bus[12:0]});
      check("bus_top", 32'h0000_A000, {16'h0, flag_bus & 16'hE000});
      ext_lvl <= 13'h1555;
      repeat (2) @(posedge clock);
      ext_lvl <= 13'h0AAA;
      repeat (10) @(posedge clock);
      check("glitch", 32'h0000_0AAA, {19'h0, flag_bus[12:0]});
      ext_lvl <= 13'h1555;
      repeat (2) @(posedge clock);
      check("too_soon", 32'h0000_0AAA, {19'h0, flag_bus[12:0]});
      repeat (10) @(posedge clock);
      check("bus_in2", 32'h0000_1555, {19'h0, flag_bus[12:0]});
      axi_wr(POL_A, 32'h0000_0F0F, RESP_OKAY);
      repeat (3) @(posedge clock);
      check("bus_in_inv", {19'h0, 13'h1555 ^ 13'h0F0F}, {19'h0, flag_bus[12:0]});
      $display("test input done");
      // original functions kept on pins 3..12
      cfg(16'h1FFF, 16'h01F8, 16'h0000);
      @(posedge clock);
      func_oe <= 13'h1E00;
      func_out <= 13'h0A00;
      ext_lvl <= 13'h0150;
      repeat (10) @(posedge clock);
      lvl = ((13'h1E00 & 13'h0A00) | (~13'h1E00 & 13'h0150)) & 13'h1FF8;
      check("func_oe", 32'h0000_1E00, {19'h0, pin_oe});
      check("func_out", 32'h0000_0A00, {19'h0, pin_out & 13'h1E00});
      check("func_in", {19'h0, lvl}, {19'h0, func_in});
      check("start_low", {26'h0, lvl[8:3] ^ 6'h3F}, {26'h0, start_active});
      axi_wr(POL_A, 32'h0000_0000, RESP_OKAY);
      repeat (3) @(posedge clock);
      check("start_high", {26'h0, lvl[8:3]}, {26'h0, start_active});
      $display("test function done");
      tally_and_finish();
   end
endmodule : flag_bus_routing_tb_top
